/* File: cso_top.sv */
// cso_top: configuration-derived outputs and legacy interrupt messages,
// with a small register port and an interrupt output for local software.
// assumes configuration writes arrive as one-cycle strobes on the core
// clock, already decoded to dword index and byte enables.
//
// Our own choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none

// Behaviour
// - bus, device and function numbers are captured from each config write.
// - six command bits are presented, bit 5 interrupt disable down to io.
// - device control bits 14 to 0 are presented continuously.
// - link control bits 7 to 0 are presented continuously.
// - a request falling edge sends an assert message and sets the status.
// - a request rising edge sends a deassert message and clears the status.
// - interrupt disable suppresses messages but the status still follows.
// - with msi enabled the msi output is high and the request is ignored.
module cso_top
   import cso_pkg::*;
(
   input wire logic CLK_I,
   input wire logic RESET_I,
   // configuration write from the transaction layer
   input wire cso_cfgwr_s CFG_WR_I,
   // legacy request from user logic, active low
   input wire logic INT_REQ_N_I,
   // local register port
   input wire logic [CSO_ADDR_W-1:0] ADDR_I,
   input wire logic [CSO_DATA_W-1:0] WDATA_I,
   input wire logic WR_I,
   input wire logic RD_I,
   output logic [CSO_DATA_W-1:0] RDATA_O,
   output logic IRQ_O,
   // configuration-derived outputs
   output logic [CSO_BUS_W-1:0] BUS_NUM_O,
   output logic [CSO_DEV_W-1:0] DEV_NUM_O,
   output logic [CSO_FUNC_W-1:0] FUNC_NUM_O,
   output logic [CSO_CMD_W-1:0] CMD_REG_O,
   output logic [CSO_DEVCTL_W-1:0] DEV_CTRL_O,
   output logic [CSO_LNKCTL_W-1:0] LINK_CTRL_O,
   output logic MSI_ENABLE_O,
   // legacy interrupt message request and status
   output logic INT_STATUS_O,
   output logic MSG_VALID_O,
   output logic MSG_ASSERT_O
);

   typedef struct packed {
      cso_id_s id;
      logic [CSO_CMD_W-1:0] cmd;
      logic [CSO_DEVCTL_W-1:0] devctl;
      logic [CSO_LNKCTL_W-1:0] lnkctl;
      logic msi_en;
      logic [CSO_EV_W-1:0] sts;
      logic [CSO_EV_W-1:0] mask;
      logic [CSO_DATA_W-1:0] rdata;
   } cso_top_st_s;

   cso_top_st_s q;
   cso_top_st_s d;

   logic intx_status;
   cso_msg_s intx_msg;
   logic [CSO_INTX_EV_W-1:0] intx_ev;
   logic [CSO_EV_W-1:0] events;
   logic [CSO_EV_W-1:0] w1c;
   logic [CSO_DATA_W-1:0] rd_word;
   logic cfg_cmd_hit;
   logic cfg_devctl_hit;
   logic cfg_lnkctl_hit;
   logic cfg_msi_hit;

   // legacy interrupt engine

   // the engine sees the registered disable, so a config write that flips
   // interrupt disable acts on edges from the following cycle onward
   cso_intx u_intx (
      .clk_i(CLK_I),
      .reset_i(RESET_I),
      .req_n_i(INT_REQ_N_I),
      .int_disable_i(q.cmd[CSO_CMD_INTDIS_BIT]),
      .msi_enable_i(q.msi_en),
      .status_o(intx_status),
      .msg_o(intx_msg),
      .event_o(intx_ev)
   );

   // configuration write decode

   assign cfg_cmd_hit = CFG_WR_I.wr && (CFG_WR_I.idx == CSO_CFG_CMD_IDX);
   assign cfg_devctl_hit = CFG_WR_I.wr &&
      (CFG_WR_I.idx == CSO_CFG_DEVCTL_IDX);
   assign cfg_lnkctl_hit = CFG_WR_I.wr &&
      (CFG_WR_I.idx == CSO_CFG_LNKCTL_IDX);
   assign cfg_msi_hit = CFG_WR_I.wr && (CFG_WR_I.idx == CSO_CFG_MSI_IDX);

   // interrupt sources

   always_comb begin
      events = '0;
      events[CSO_INTX_EV_W-1:0] = intx_ev;
      events[CSO_EV_CFG_WR] = CFG_WR_I.wr;
   end

   always_comb begin
      w1c = '0;
      if (WR_I && (ADDR_I == CSO_REG_IRQ_STS)) begin
         w1c = WDATA_I[CSO_EV_W-1:0];
      end
   end

   // read multiplexer

   // unmapped offsets read as zero
   always_comb begin
      rd_word = '0;
      case (ADDR_I)
         CSO_REG_ID: begin
            rd_word[CSO_BUS_W+CSO_DEV_W+CSO_FUNC_W-1:0] = q.id;
         end
         CSO_REG_CMD: begin
            rd_word[CSO_CMD_W-1:0] = q.cmd;
            rd_word[CSO_STAT_INT_BIT] = intx_status;
            rd_word[CSO_MSI_EN_BIT] = q.msi_en;
         end
         CSO_REG_DEVCTL: begin
            rd_word[CSO_DEVCTL_W-1:0] = q.devctl;
         end
         CSO_REG_LNKCTL: begin
            rd_word[CSO_LNKCTL_W-1:0] = q.lnkctl;
         end
         CSO_REG_IRQ_STS: begin
            rd_word[CSO_EV_W-1:0] = q.sts;
         end
         CSO_REG_IRQ_MASK: begin
            rd_word[CSO_EV_W-1:0] = q.mask;
         end
         default: begin
            rd_word = '0;
         end
      endcase
   end

   // next state

   always_comb begin
      d = q;

      // every config write carries the requester-assigned id
      if (CFG_WR_I.wr) begin
         d.id = CFG_WR_I.id;
      end

      // command bits live in byte 0 of the command dword
      if (cfg_cmd_hit && CFG_WR_I.be[0]) begin
         d.cmd = CFG_WR_I.data[CSO_CMD_W-1:0];
      end

      // device control spans bytes 0 and 1; bit 15 is not kept
      if (cfg_devctl_hit && CFG_WR_I.be[0]) begin
         d.devctl[7:0] = CFG_WR_I.data[7:0];
      end
      if (cfg_devctl_hit && CFG_WR_I.be[1]) begin
         d.devctl[CSO_DEVCTL_W-1:8] = CFG_WR_I.data[CSO_DEVCTL_W-1:8];
      end

      if (cfg_lnkctl_hit && CFG_WR_I.be[0]) begin
         d.lnkctl = CFG_WR_I.data[CSO_LNKCTL_W-1:0];
      end

      // msi enable sits in byte 2 of the msi capability header
      if (cfg_msi_hit && CFG_WR_I.be[2]) begin
         d.msi_en = CFG_WR_I.data[CSO_MSI_EN_BIT];
      end

      // a new event in the same cycle as its clear keeps the bit set
      d.sts = (q.sts & ~w1c) | events;

      if (WR_I && (ADDR_I == CSO_REG_IRQ_MASK)) begin
         d.mask = WDATA_I[CSO_EV_W-1:0];
      end

      // read data stand only in the cycle after the strobe
      d.rdata = RD_I ? rd_word : '0;
   end

   // state register

   always_ff @(posedge CLK_I) begin
      if (RESET_I) begin
         q.id <= '0;
         q.cmd <= CSO_CMD_RST;
         q.devctl <= CSO_DEVCTL_RST;
         q.lnkctl <= CSO_LNKCTL_RST;
         q.msi_en <= 1'b0;
         q.sts <= '0;
         q.mask <= CSO_IRQ_MASK_RST;
         q.rdata <= '0;
      end else begin
         q <= d;
      end
   end

   // outputs

   assign BUS_NUM_O = q.id.bus;
   assign DEV_NUM_O = q.id.dev;
   assign FUNC_NUM_O = q.id.func;
   assign CMD_REG_O = q.cmd;
   assign DEV_CTRL_O = q.devctl;
   assign LINK_CTRL_O = q.lnkctl;
   assign MSI_ENABLE_O = q.msi_en;

   assign INT_STATUS_O = intx_status;
   assign MSG_VALID_O = intx_msg.valid;
   assign MSG_ASSERT_O = intx_msg.assert_n_deassert;

   assign RDATA_O = q.rdata;
   assign IRQ_O = |(q.sts & q.mask);

endmodule : cso_top

`default_nettype wire

/* File: cso_pkg.sv */
// cso_pkg: widths, field positions, offsets, reset values and carrier types
// of the configuration status and legacy interrupt block.
// assumes a single core clock and a synchronous active-high reset.
`default_nettype none

package cso_pkg;

   // output field widths
   localparam int unsigned CSO_BUS_W = 8;
   localparam int unsigned CSO_DEV_W = 5;
   localparam int unsigned CSO_FUNC_W = 3;
   localparam int unsigned CSO_CMD_W = 6;
   localparam int unsigned CSO_DEVCTL_W = 15;
   localparam int unsigned CSO_LNKCTL_W = 8;

   // configuration write carrier
   localparam int unsigned CSO_CFG_IDX_W = 10;
   localparam int unsigned CSO_CFG_DATA_W = 32;
   localparam int unsigned CSO_CFG_BE_W = 4;

   // local register port
   localparam int unsigned CSO_ADDR_W = 8;
   localparam int unsigned CSO_DATA_W = 32;

   // command register bit positions
   localparam int unsigned CSO_CMD_IO_BIT = 0;
   localparam int unsigned CSO_CMD_MEM_BIT = 1;
   localparam int unsigned CSO_CMD_MASTER_BIT = 2;
   localparam int unsigned CSO_CMD_PERR_BIT = 3;
   localparam int unsigned CSO_CMD_SERR_BIT = 4;
   localparam int unsigned CSO_CMD_INTDIS_BIT = 5;

   // bit positions inside configuration dwords
   localparam int unsigned CSO_STAT_INT_BIT = 19;
   localparam int unsigned CSO_MSI_EN_BIT = 16;

   // configuration dword indices
   localparam logic [9:0] CSO_CFG_CMD_IDX = 10'h001;
   localparam logic [9:0] CSO_CFG_MSI_IDX = 10'h014;
   localparam logic [9:0] CSO_CFG_DEVCTL_IDX = 10'h01a;
   localparam logic [9:0] CSO_CFG_LNKCTL_IDX = 10'h01c;

   // local register byte offsets
   localparam logic [7:0] CSO_REG_ID = 8'h00;
   localparam logic [7:0] CSO_REG_CMD = 8'h04;
   localparam logic [7:0] CSO_REG_DEVCTL = 8'h08;
   localparam logic [7:0] CSO_REG_LNKCTL = 8'h0c;
   localparam logic [7:0] CSO_REG_IRQ_STS = 8'h10;
   localparam logic [7:0] CSO_REG_IRQ_MASK = 8'h14;

   // event bits of the interrupt status and mask registers
   localparam int unsigned CSO_EV_W = 5;
   localparam int unsigned CSO_INTX_EV_W = 4;
   localparam int unsigned CSO_EV_ASSERT = 0;
   localparam int unsigned CSO_EV_DEASSERT = 1;
   localparam int unsigned CSO_EV_SUPPRESSED = 2;
   localparam int unsigned CSO_EV_MSI_IGNORED = 3;
   localparam int unsigned CSO_EV_CFG_WR = 4;

   // reset values
   localparam logic [5:0] CSO_CMD_RST = 6'h00;
   localparam logic [14:0] CSO_DEVCTL_RST = 15'h0000;
   localparam logic [7:0] CSO_LNKCTL_RST = 8'h00;
   localparam logic [4:0] CSO_IRQ_MASK_RST = 5'h00;

   typedef struct packed {
      logic [CSO_BUS_W-1:0] bus;
      logic [CSO_DEV_W-1:0] dev;
      logic [CSO_FUNC_W-1:0] func;
   } cso_id_s;

   typedef struct packed {
      logic wr;
      logic [CSO_CFG_IDX_W-1:0] idx;
      logic [CSO_CFG_BE_W-1:0] be;
      logic [CSO_CFG_DATA_W-1:0] data;
      cso_id_s id;
   } cso_cfgwr_s;

   typedef struct packed {
      logic valid;
      logic assert_n_deassert;
   } cso_msg_s;

   typedef enum logic [1:0] {
      CSO_INTX_IDLE = 2'b01,
      CSO_INTX_ACTIVE = 2'b10
   } cso_intx_e;

endpackage : cso_pkg

`default_nettype wire

/* File: cso_intx.sv */
// cso_intx: turns the active-low legacy request into assert and deassert
// message pulses and keeps the interrupt status bit.
// assumes the request comes from logic on the same clock.
`timescale 1ns/10ps
`default_nettype none

module cso_intx
   import cso_pkg::*;
(
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic req_n_i,
   input wire logic int_disable_i,
   input wire logic msi_enable_i,
   output logic status_o,
   output cso_msg_s msg_o,
   output logic [CSO_INTX_EV_W-1:0] event_o
);

   typedef struct packed {
      cso_intx_e st;
      logic prev_n;
      cso_msg_s msg;
      logic [CSO_INTX_EV_W-1:0] ev;
   } cso_intx_st_s;

   cso_intx_st_s q;
   cso_intx_st_s d;
   logic fall;
   logic rise;

   // previous sample against current one
   assign fall = q.prev_n & ~req_n_i;
   assign rise = ~q.prev_n & req_n_i;

   always_comb begin
      d = q;
      d.msg = '0;
      d.ev = '0;
      // prev tracks even while ignored, so no stale edge when msi drops
      d.prev_n = req_n_i;
      if (msi_enable_i) begin
         d.ev[CSO_EV_MSI_IGNORED] = fall | rise;
      end else begin
         case (q.st)
            CSO_INTX_IDLE: begin
               if (fall) begin
                  d.st = CSO_INTX_ACTIVE;
                  d.msg.valid = ~int_disable_i;
                  d.msg.assert_n_deassert = 1'b1;
                  d.ev[CSO_EV_ASSERT] = ~int_disable_i;
                  d.ev[CSO_EV_SUPPRESSED] = int_disable_i;
               end
            end
            CSO_INTX_ACTIVE: begin
               if (rise) begin
                  d.st = CSO_INTX_IDLE;
                  d.msg.valid = ~int_disable_i;
                  d.msg.assert_n_deassert = 1'b0;
                  d.ev[CSO_EV_DEASSERT] = ~int_disable_i;
                  d.ev[CSO_EV_SUPPRESSED] = int_disable_i;
               end
            end
            default: begin
               d.st = CSO_INTX_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         q.st <= CSO_INTX_IDLE;
         q.prev_n <= 1'b1;
         q.msg <= '0;
         q.ev <= '0;
      end else begin
         q <= d;
      end
   end

   assign status_o = (q.st == CSO_INTX_ACTIVE);
   assign msg_o = q.msg;
   assign event_o = q.ev;

endmodule : cso_intx

`default_nettype wire

/* File: cso_top_asserts.sv */
// cso_top_asserts: port-level properties of cso_top.
// assumes one clock and a synchronous active-high reset.
`timescale 1ns/10ps
`default_nettype none

module cso_top_asserts
   import cso_pkg::*;
(
   input wire logic CLK_I,
   input wire logic RESET_I,
   input wire cso_cfgwr_s CFG_WR_I,
   input wire logic INT_REQ_N_I,
   input wire logic [CSO_BUS_W-1:0] BUS_NUM_O,
   input wire logic [CSO_DEV_W-1:0] DEV_NUM_O,
   input wire logic [CSO_FUNC_W-1:0] FUNC_NUM_O,
   input wire logic [CSO_CMD_W-1:0] CMD_REG_O,
   input wire logic [CSO_DEVCTL_W-1:0] DEV_CTRL_O,
   input wire logic [CSO_LNKCTL_W-1:0] LINK_CTRL_O,
   input wire logic MSI_ENABLE_O,
   input wire logic INT_STATUS_O,
   input wire logic MSG_VALID_O,
   input wire logic MSG_ASSERT_O
);
   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (RESET_I);
   logic wr_cmd, wr_dc, wr_lc, live;
   assign wr_cmd = CFG_WR_I.wr && CFG_WR_I.idx == CSO_CFG_CMD_IDX;
   assign wr_dc = CFG_WR_I.wr && CFG_WR_I.idx == CSO_CFG_DEVCTL_IDX;
   assign wr_lc = CFG_WR_I.wr && CFG_WR_I.idx == CSO_CFG_LNKCTL_IDX;
   assign live = !MSI_ENABLE_O && !CMD_REG_O[CSO_CMD_INTDIS_BIT];

   AST_CFG_ID: assert property (CFG_WR_I.wr |=>
      {BUS_NUM_O, DEV_NUM_O, FUNC_NUM_O} == $past(CFG_WR_I.id))
      else $error("id not captured");
   AST_CFG_CMD: assert property (wr_cmd && CFG_WR_I.be[0] |=>
      CMD_REG_O == $past(CFG_WR_I.data[5:0]))
      else $error("command bits not captured");
   AST_CFG_DEVCTL: assert property (wr_dc && CFG_WR_I.be[0] |=>
      DEV_CTRL_O[7:0] == $past(CFG_WR_I.data[7:0]))
      else $error("device control not captured");
   AST_CFG_LNKCTL: assert property (wr_lc && CFG_WR_I.be[0] |=>
      LINK_CTRL_O == $past(CFG_WR_I.data[7:0]))
      else $error("link control not captured");
   AST_ASSERT_MSG: assert property ($fell(INT_REQ_N_I) && live
      && !INT_STATUS_O |=> MSG_VALID_O && MSG_ASSERT_O)
      else $error("assert message missing");
   AST_DEASSERT_MSG: assert property ($rose(INT_REQ_N_I) && live
      && INT_STATUS_O |=> MSG_VALID_O && !MSG_ASSERT_O)
      else $error("deassert message missing");
   AST_STATUS_SET: assert property ($fell(INT_REQ_N_I)
      && !MSI_ENABLE_O |=> INT_STATUS_O)
      else $error("status not set");
   AST_STATUS_CLR: assert property ($rose(INT_REQ_N_I)
      && !MSI_ENABLE_O |=> !INT_STATUS_O)
      else $error("status not cleared");
   AST_DISABLE_QUIET: assert property (CMD_REG_O[5] |=>
      !MSG_VALID_O)
      else $error("message sent while disabled");
   AST_MSI_IGNORE: assert property (MSI_ENABLE_O |=>
      $stable(INT_STATUS_O) && !MSG_VALID_O)
      else $error("request not ignored under msi");
   // the engine's sample history restarts at reset, so skip that case
   AST_EDGE_CAUSE: assert property (MSG_VALID_O && !$past(RESET_I, 2)
      |-> $past(INT_REQ_N_I) != $past(INT_REQ_N_I, 2))
      else $error("message without request edge");
endmodule : cso_top_asserts

bind cso_top cso_top_asserts cso_top_asserts_inst (.CLK_I(CLK_I),
   .RESET_I(RESET_I), .CFG_WR_I(CFG_WR_I), .INT_REQ_N_I(INT_REQ_N_I),
   .BUS_NUM_O(BUS_NUM_O), .DEV_NUM_O(DEV_NUM_O), .FUNC_NUM_O(FUNC_NUM_O),
   .CMD_REG_O(CMD_REG_O), .DEV_CTRL_O(DEV_CTRL_O),
   .LINK_CTRL_O(LINK_CTRL_O), .MSI_ENABLE_O(MSI_ENABLE_O),
   .INT_STATUS_O(INT_STATUS_O), .MSG_VALID_O(MSG_VALID_O),
   .MSG_ASSERT_O(MSG_ASSERT_O));

`default_nettype wire

/* File: cso_user_model.sv */
// cso_user_model: user logic driving the active-low legacy request.
// assumes the core clock and reset of the block under test.
`timescale 1ns/10ps
`default_nettype none

module cso_user_model #(
   parameter int GAP = 8
) (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic want_i,
   input wire logic intdis_i,
   input wire logic auto_or_i,
   output logic req_n_o
);
   logic lvl_q;
   int cnt_q;
   // the wider x1 spacing is kept always, safe for every variant
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         lvl_q <= 1'b1;
         cnt_q <= 0;
      end else if (lvl_q == want_i && cnt_q >= GAP) begin
         lvl_q <= !want_i;
         cnt_q <= 0;
      end else if (cnt_q < GAP) begin
         cnt_q <= cnt_q + 1;
      end
   end
   assign req_n_o = lvl_q | (auto_or_i & intdis_i);
endmodule : cso_user_model

`default_nettype wire

/* File: testbench.sv */
// testbench: random config writes and legacy request scenarios.
// assumes cso_top, its checker bind and the user model are compiled.
`timescale 1ns/10ps
`default_nettype none

`define CHK(n, e, g) begin checks_done++; \
   if ((g) !== (e)) begin miscompares++; \
   $display("FAIL %s exp %h got %h", n, e, g); end end

module testbench;
   import cso_pkg::*;
   logic clk = 1'b0, reset = 1'b1, wr_s = 1'b0, rd_s = 1'b0;
   logic want = 1'b0, auto_or = 1'b0, req_n, irq, msi, st, mv, ma;
   cso_cfgwr_s cfg_wr = '0;
   logic [7:0] addr = '0, bus, lc, e_lc;
   logic [31:0] wdata = '0, rdata, v;
   logic [4:0] dev;
   logic [2:0] func;
   logic [5:0] cmd, e_cmd;
   logic [14:0] dc, e_dc;
   logic e_msi;
   int miscompares = 0, checks_done = 0, cyc = 0, n_as = 0, n_de = 0;
   logic [9:0] tbl [5] = '{CSO_CFG_CMD_IDX, CSO_CFG_MSI_IDX,
      CSO_CFG_DEVCTL_IDX, CSO_CFG_LNKCTL_IDX, 10'h3ff};

   cso_top cso_top_inst (.CLK_I(clk), .RESET_I(reset), .CFG_WR_I(cfg_wr),
      .INT_REQ_N_I(req_n), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr_s),
      .RD_I(rd_s), .RDATA_O(rdata), .IRQ_O(irq), .BUS_NUM_O(bus),
      .DEV_NUM_O(dev), .FUNC_NUM_O(func), .CMD_REG_O(cmd),
      .DEV_CTRL_O(dc), .LINK_CTRL_O(lc), .MSI_ENABLE_O(msi),
      .INT_STATUS_O(st), .MSG_VALID_O(mv), .MSG_ASSERT_O(ma));
   cso_user_model #(.GAP(8)) cso_user_model_inst (.clk_i(clk),
      .reset_i(reset), .want_i(want), .intdis_i(cmd[5]),
      .auto_or_i(auto_or), .req_n_o(req_n));

   always #10 clk = ~clk;

   task automatic stop_test;
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : stop_test

   // a run of a few thousand cycles means something hung
   always @(posedge clk) begin
      cyc++;
      if (mv === 1'b1) begin
         if (ma) n_as++;
         else n_de++;
      end
      if (cyc == 6000) begin
         miscompares++;
         stop_test();
      end
   end

   function automatic logic [31:0] reg04(logic [5:0] c, logic m, logic s);
      return {12'h0, s, 2'h0, m, 10'h0, c};
   endfunction : reg04

   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      wr_s <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr_s <= 1'b0;
   endtask : wr_reg

   task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      rd_s <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd_s <= 1'b0;
      #1 d = rdata;
   endtask : rd_reg

   task automatic cfg(input logic [9:0] ix, input logic [3:0] be,
      input logic [31:0] d);
      cso_id_s id;
      id = cso_id_s'(16'($urandom));
      @(posedge clk);
      cfg_wr <= '{wr: 1'b1, idx: ix, be: be, data: d, id: id};
      if (ix == CSO_CFG_CMD_IDX && be[0]) e_cmd = d[5:0];
      if (ix == CSO_CFG_DEVCTL_IDX && be[0]) e_dc[7:0] = d[7:0];
      if (ix == CSO_CFG_DEVCTL_IDX && be[1]) e_dc[14:8] = d[14:8];
      if (ix == CSO_CFG_LNKCTL_IDX && be[0]) e_lc = d[7:0];
      if (ix == CSO_CFG_MSI_IDX && be[2]) e_msi = d[16];
      @(posedge clk);
      cfg_wr.wr <= 1'b0;
      #1;
      `CHK("id", id, {bus, dev, func})
      `CHK("cmd", e_cmd, cmd)
      `CHK("devctl", e_dc, dc)
      `CHK("lnkctl", e_lc, lc)
      `CHK("msi", e_msi, msi)
   endtask : cfg

   task automatic irq_edge(input logic lv, input int das, input int dde,
      input logic s);
      int a0, d0;
      a0 = n_as;
      d0 = n_de;
      @(posedge clk);
      want <= lv;
      for (int i = 0; i < 12 && req_n !== !lv; i++) @(posedge clk);
      repeat (3) @(posedge clk);
      #1;
      `CHK("assert msgs", das, n_as - a0)
      `CHK("deassert msgs", dde, n_de - d0)
      `CHK("status", s, st)
   endtask : irq_edge

   initial begin
      void'($urandom(68792));
      {e_cmd, e_dc, e_lc, e_msi} = '0;
      repeat (16) @(posedge clk);
      reset <= 1'b0;
      #1 `CHK("reset outs", 32'h0, {irq, st, mv, cmd, dc, msi})
      rd_reg(CSO_REG_IRQ_MASK, v);
      `CHK("mask rst", 32'(CSO_IRQ_MASK_RST), v)
      cfg(CSO_CFG_DEVCTL_IDX, 4'h2, '1);
      for (int i = 0; i < 30; i++) cfg(tbl[$urandom % 5], 4'($urandom),
         $urandom);
      cfg(CSO_CFG_CMD_IDX, 4'h1, 32'h0);
      cfg(CSO_CFG_MSI_IDX, 4'h4, 32'h0);
      wr_reg(CSO_REG_IRQ_STS, 32'h1f);
      wr_reg(CSO_REG_IRQ_MASK, 32'h1f);
      irq_edge(1'b1, 1, 0, 1'b1);
      `CHK("irq", 1'b1, irq)
      rd_reg(CSO_REG_CMD, v);
      `CHK("reg04", reg04(e_cmd, 1'b0, 1'b1), v)
      rd_reg(CSO_REG_IRQ_STS, v);
      `CHK("events", 32'h1, v)
      wr_reg(CSO_REG_IRQ_STS, 32'h1);
      #1 `CHK("irq clr", 1'b0, irq)
      irq_edge(1'b0, 0, 1, 1'b0);
      cfg(CSO_CFG_CMD_IDX, 4'h1, 32'h20);
      irq_edge(1'b1, 0, 0, 1'b1);
      irq_edge(1'b0, 0, 0, 1'b0);
      rd_reg(CSO_REG_IRQ_STS, v);
      `CHK("events dis", 32'h16, v)
      auto_or <= 1'b1;
      cfg(CSO_CFG_CMD_IDX, 4'h1, 32'h0);
      irq_edge(1'b1, 1, 0, 1'b1);
      cfg(CSO_CFG_CMD_IDX, 4'h1, 32'h20);
      irq_edge(1'b1, 0, 0, 1'b0);
      irq_edge(1'b0, 0, 0, 1'b0);
      auto_or <= 1'b0;
      cfg(CSO_CFG_CMD_IDX, 4'h1, 32'h0);
      cfg(CSO_CFG_MSI_IDX, 4'h4, 32'h10000);
      irq_edge(1'b1, 0, 0, 1'b0);
      irq_edge(1'b0, 0, 0, 1'b0);
      cfg(CSO_CFG_MSI_IDX, 4'h4, 32'h0);
      wr_reg(8'h20, $urandom);
      rd_reg(8'h20, v);
      `CHK("unmapped", 32'h0, v)
      wr_reg(CSO_REG_DEVCTL, '1);
      rd_reg(CSO_REG_DEVCTL, v);
      `CHK("devctl ro", 32'(e_dc), v)
      wr_reg(CSO_REG_IRQ_MASK, 32'h0);
      irq_edge(1'b1, 1, 0, 1'b1);
      `CHK("irq masked", 1'b0, irq)
      irq_edge(1'b0, 0, 1, 1'b0);
      @(posedge clk);
      reset <= 1'b1;
      repeat (2) @(posedge clk);
      reset <= 1'b0;
      #1 `CHK("rst again", 32'h0, {irq, st, mv, cmd, dc, msi})
      stop_test();
   end
endmodule : testbench

`default_nettype wire
